// ==== ssd_core.sv ====
// SPI status, error flags, baud select and data buffers behind an APB slave.
// Assumes pin inputs are asynchronous to pclk and the pad logic resolves the enables.
//
// The APB register port was left to the implementer.
`timescale 1ns/100ps
`include "ssd_params.svh"

// Overview of operation
// - Completed byte sets receive full, may interrupt.
// - Any data read clears receive full.
// - Error enable gates overrun and fault interrupts.
// - Overrun keeps old byte, drops new one.
// - Overrun clears by status read, data read.
// - Fault on slave select misuse by mode.
// - Fault clears by status read, data write.
// - Buffer-to-shifter transfer sets transmit empty.
// - Idle shifter takes written byte within two cycles.
// - Busy slave shifter waits for transfer end.
// - Reset sets transmit empty, clears receive full.
// - Fault sets only with fault enable high.
// - Master without fault enable frees select pin.
// - Slave always uses select pin as input.
// - Baud code picks divisor 2, 8, 32, 128.
// - Serial clock is base over twice divisor.
// - Data writes transmit, reads receive buffer.
// - Data buffers have no reset value.
// - Deselected slave floats output, ignores clocks.
// - Master select resets to master mode.
module ssd_core
    import ssd_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Interrupt request to the CPU
    output logic             irq_request,
    // Serial clock pin
    input  wire logic        sclk_in,
    output logic             sclk_out,
    output logic             sclk_oe,
    // Master-out slave-in pin
    input  wire logic        mosi_in,
    output logic             mosi_out,
    output logic             mosi_oe,
    // Master-in slave-out pin
    input  wire logic        miso_in,
    output logic             miso_out,
    output logic             miso_oe,
    // Slave select pin and its ownership
    input  wire logic        ss_n_in,
    output logic             ss_pin_is_gpio
);

    // Divisor for a baud select code.
    function automatic logic [7:0] baud_div(input logic [1:0] sel);
        unique case (sel)
            2'b00: baud_div = `SSD_BD_CODE0;
            2'b01: baud_div = `SSD_BD_CODE1;
            2'b10: baud_div = `SSD_BD_CODE2;
            2'b11: baud_div = `SSD_BD_CODE3;
        endcase
    endfunction

    logic [7:0]  ctrl_reg;
    logic        error_irq_enable, mode_fault_enable;
    logic [1:0]  baud_sel;
    logic        rx_full_flag, overrun_flag, mode_fault_flag, tx_full_reg, ovr_armed_reg, mode_fault_flag_armed_reg;
    ssd_byte_t   tx_buf_reg, rx_buf_reg, shift_reg;
    logic        rx_bit_reg;
    logic [2:0]  bit_cnt_reg;
    logic        slave_busy;
    ssd_mstate_t mstate_reg;
    logic        sclk_reg;
    logic [3:0]  sync1_reg, sync2_reg, sync3_reg, pin_s_reg, pin_d_reg;
    logic [31:0] prdata_reg;
    logic        tick;

    // Decoded controls, bus strobes, synchronised pins and events.
    logic        rx_irq_enable, tx_irq_enable, master_select, spi_enable, tx_empty_flag;
    logic        acc, wr_ctrl, wr_stat, wr_data, rd_stat, rd_data, mapped, is_master, is_slave;
    logic        ss_s, sclk_s, mosi_s, miso_s, slave_rise, slave_fall, ss_rise;
    logic        load_shifter, byte_done, mode_fault_flag_set;

    assign rx_irq_enable = ctrl_reg[`SSD_CTRL_RXIE];
    assign tx_irq_enable = ctrl_reg[`SSD_CTRL_TXIE];
    assign master_select = ctrl_reg[`SSD_CTRL_MSTR];
    assign spi_enable    = ctrl_reg[`SSD_CTRL_SPE];
    assign tx_empty_flag = !tx_full_reg;
    assign is_master     = spi_enable && master_select;
    assign is_slave      = spi_enable && !master_select;

    // Bus decode; the slave never waits, so every access completes in its first access cycle.
    assign acc     = psel && penable;
    assign mapped  = (paddr == `SSD_ADDR_CTRL) || (paddr == `SSD_ADDR_STAT) || (paddr == `SSD_ADDR_DATA);
    assign wr_ctrl = acc && pwrite && pstrb[0] && (paddr == `SSD_ADDR_CTRL);
    assign wr_stat = acc && pwrite && pstrb[0] && (paddr == `SSD_ADDR_STAT);
    assign wr_data = acc && pwrite && pstrb[0] && (paddr == `SSD_ADDR_DATA);
    assign rd_stat = acc && !pwrite && (paddr == `SSD_ADDR_STAT);
    assign rd_data = acc && !pwrite && (paddr == `SSD_ADDR_DATA);
    assign pready  = 1'b1;
    assign pslverr = acc && !mapped;
    assign prdata  = prdata_reg;

    // Read data is latched in the setup cycle so it comes from a flop yet is ready at once.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            if (paddr == `SSD_ADDR_CTRL) begin
                prdata_reg <= {24'h00_0000, ctrl_reg};
            end else if (paddr == `SSD_ADDR_STAT) begin
                prdata_reg <= {24'h00_0000, rx_full_flag, error_irq_enable, overrun_flag, mode_fault_flag,
                               tx_empty_flag, mode_fault_enable, baud_sel};
            end else if (paddr == `SSD_ADDR_DATA) begin
                prdata_reg <= {24'h00_0000, rx_buf_reg};
            end else begin
                prdata_reg <= 32'h0000_0000;
            end
        end
    end

    // Control register; the port starts as a master.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= `SSD_CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_reg <= pwdata[7:0] & 8'ha3;
        end
    end

    // Writable status bits: error enable, fault enable and baud select.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            error_irq_enable  <= 1'b0;
            mode_fault_enable <= 1'b0;
            baud_sel          <= 2'b00;
        end else if (wr_stat) begin
            error_irq_enable  <= pwdata[`SSD_STAT_ERROR_IRQ_ENABLE];
            mode_fault_enable <= pwdata[`SSD_STAT_MFEN];
            baud_sel          <= pwdata[`SSD_STAT_BDHI:`SSD_STAT_BDLO];
        end
    end

    // Pin synchronisers: a level counts only once the second and third stages agree.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= `SSD_PIN_IDLE;
            sync2_reg <= `SSD_PIN_IDLE;
            sync3_reg <= `SSD_PIN_IDLE;
            pin_d_reg <= `SSD_PIN_IDLE;
        end else begin
            sync1_reg <= {ss_n_in, sclk_in, mosi_in, miso_in};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            pin_d_reg <= pin_s_reg;
        end
    end

    localparam logic [3:0] PIN_IDLE = `SSD_PIN_IDLE; // Reset to idle levels, so no false edge follows.
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_pin
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pin_s_reg[gi] <= PIN_IDLE[gi];
                end else if (sync2_reg[gi] == sync3_reg[gi]) begin
                    pin_s_reg[gi] <= sync3_reg[gi];
                end
            end
        end
    endgenerate

    assign ss_s   = pin_s_reg[3];
    assign sclk_s = pin_s_reg[2];
    assign mosi_s = pin_s_reg[1];
    assign miso_s = pin_s_reg[0];
    assign ss_rise = ss_s && !pin_d_reg[3];
    // A deselected slave sees no clock edges at all, even mid-byte.
    assign slave_rise = is_slave && !ss_s && sclk_s && !pin_d_reg[2];
    assign slave_fall = is_slave && !ss_s && !sclk_s && pin_d_reg[2];
    assign slave_busy = is_slave && (bit_cnt_reg != 3'h0);

    // Master half-period ticks; the tick rate is pclk over the divisor.
    ssd_baud_gen u_baud (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (mstate_reg == SSD_M_RUN),
        .div     (baud_div(baud_sel)),
        .tick    (tick)
    );

    // A busy slave keeps its shifter, so a second write waits in the transmit buffer.
    assign load_shifter = tx_full_reg && ((is_master && mstate_reg == SSD_M_IDLE) ||
                                          (is_slave && !slave_busy));
    assign byte_done = (mstate_reg == SSD_M_RUN && tick && sclk_reg && bit_cnt_reg == `SSD_BITS_LAST) ||
                       (slave_fall && bit_cnt_reg == `SSD_BITS_LAST);

    // Fault sources: a master sees select low, a slave sees select rise mid-byte.
    assign mode_fault_flag_set = mode_fault_enable && ((is_master && !ss_s) ||
                                            (is_slave && ss_rise && bit_cnt_reg != 3'h0));

    // Master sequencer; a fault drops the byte and returns to idle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mstate_reg <= SSD_M_IDLE;
            sclk_reg   <= 1'b0;
        end else if (!is_master || mode_fault_flag_set) begin
            mstate_reg <= SSD_M_IDLE;
            sclk_reg   <= 1'b0;
        end else begin
            unique case (mstate_reg)
                SSD_M_IDLE: begin
                    if (load_shifter) begin
                        mstate_reg <= SSD_M_RUN;
                    end
                end
                SSD_M_RUN: begin
                    if (tick) begin
                        sclk_reg <= !sclk_reg;
                        if (byte_done) begin
                            mstate_reg <= SSD_M_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Bit counter, shared by both modes; a sample is taken on rise and shifted in on fall.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_cnt_reg <= 3'h0;
            rx_bit_reg  <= 1'b0;
        end else if (!spi_enable || (is_master && (mstate_reg == SSD_M_IDLE || mode_fault_flag_set))) begin
            bit_cnt_reg <= 3'h0;
        end else if ((is_master && tick && !sclk_reg) || slave_rise) begin
            rx_bit_reg <= is_master ? miso_s : mosi_s;
        end else if ((is_master && tick && sclk_reg) || slave_fall) begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
        end
    end

    // Data storage has no reset; software must not rely on its contents.
    always_ff @(posedge pclk) begin
        if (wr_data) begin
            tx_buf_reg <= pwdata[7:0];
        end
        if (load_shifter) begin
            shift_reg <= tx_buf_reg;
        end else if ((is_master && tick && sclk_reg) || slave_fall) begin
            shift_reg <= {shift_reg[6:0], rx_bit_reg};
        end
        if (byte_done && !rx_full_flag) begin
            rx_buf_reg <= {shift_reg[6:0], rx_bit_reg};
        end
    end

    // Transmit buffer state; a write fills it and the shifter load empties it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_full_reg <= 1'b0;
        end else if (wr_data) begin
            tx_full_reg <= 1'b1;
        end else if (load_shifter) begin
            tx_full_reg <= 1'b0;
        end
    end

    // Receive full: a new byte into an empty buffer wins over a data read in the same cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_full_flag <= 1'b0;
        end else if (byte_done && !rx_full_flag) begin
            rx_full_flag <= 1'b1;
        end else if (rd_data) begin
            rx_full_flag <= 1'b0;
        end
    end

    // Overrun and its two-step clear; a status read arms, a data read completes.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overrun_flag  <= 1'b0;
            ovr_armed_reg <= 1'b0;
        end else begin
            if (byte_done && rx_full_flag) begin
                overrun_flag <= 1'b1;
            end else if (rd_data && ovr_armed_reg) begin
                overrun_flag <= 1'b0;
            end
            if (rd_stat && overrun_flag) begin
                ovr_armed_reg <= 1'b1;
            end else if (rd_data) begin
                ovr_armed_reg <= 1'b0;
            end
        end
    end

    // Mode fault and its clear; the fault enable gates setting only, never clearing.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_fault_flag <= 1'b0;
            mode_fault_flag_armed_reg  <= 1'b0;
        end else begin
            if (mode_fault_flag_set) begin
                mode_fault_flag <= 1'b1;
            end else if (wr_data && mode_fault_flag_armed_reg) begin
                mode_fault_flag <= 1'b0;
            end
            if (rd_stat && mode_fault_flag) begin
                mode_fault_flag_armed_reg <= 1'b1;
            end else if (wr_data) begin
                mode_fault_flag_armed_reg <= 1'b0;
            end
        end
    end

    // Interrupt request and pin drive.
    assign irq_request = (rx_irq_enable && rx_full_flag) || (tx_irq_enable && tx_empty_flag) ||
                         (error_irq_enable && (overrun_flag || mode_fault_flag));
    assign sclk_out = sclk_reg;
    assign sclk_oe  = is_master;
    assign mosi_out = shift_reg[7];
    assign mosi_oe  = is_master;
    assign miso_out = shift_reg[7];
    assign miso_oe  = is_slave && !ss_s;
    assign ss_pin_is_gpio = !spi_enable || (is_master && !mode_fault_enable);

    // Checks next to the logic they guard.
    chk_rx_full_set: assert property (@(posedge pclk) disable iff (!presetn)
        byte_done && !rx_full_flag |=> rx_full_flag) else $error("receive full not set");
    chk_rx_full_clr: assert property (@(posedge pclk) disable iff (!presetn)
        rd_data && !byte_done |=> !rx_full_flag) else $error("receive full not cleared");
    chk_err_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
        error_irq_enable && (overrun_flag || mode_fault_flag) |-> irq_request) else $error("error irq missing");
    chk_overrun_keep: assert property (@(posedge pclk) disable iff (!presetn)
        byte_done && rx_full_flag |=> overrun_flag && $stable(rx_buf_reg)) else $error("overrun wrong");
    chk_overrun_clear: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(overrun_flag) |-> $past(rd_data) && $past(ovr_armed_reg)) else $error("overrun cleared early");
    chk_mode_fault_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(mode_fault_flag) |-> $past(wr_data) && $past(mode_fault_flag_armed_reg)) else $error("fault cleared early");
    chk_mode_fault_flag_enable: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(mode_fault_flag) |-> $past(mode_fault_enable)) else $error("fault set while disabled");
    chk_master_fault: assert property (@(posedge pclk) disable iff (!presetn)
        is_master && mode_fault_enable && !ss_s |=> mode_fault_flag && mstate_reg == SSD_M_IDLE)
        else $error("master fault missed");
    chk_tx_refill: assert property (@(posedge pclk) disable iff (!presetn)
        wr_data && is_master && mstate_reg == SSD_M_IDLE |-> ##[1:2] tx_empty_flag) else $error("no refill");
    chk_slave_hold: assert property (@(posedge pclk) disable iff (!presetn)
        slave_busy |-> !load_shifter) else $error("busy slave reloaded");
    chk_miso_float: assert property (@(posedge pclk) disable iff (!presetn)
        ss_s || master_select |-> !miso_oe) else $error("miso driven while deselected");
    cov_master_byte: cover property (@(posedge pclk) disable iff (!presetn) is_master && byte_done);
    cov_slave_byte: cover property (@(posedge pclk) disable iff (!presetn) is_slave && byte_done);
    cov_overrun: cover property (@(posedge pclk) disable iff (!presetn) $rose(overrun_flag));
    cov_fault_clear: cover property (@(posedge pclk) disable iff (!presetn) $fell(mode_fault_flag));

endmodule // ssd_core

// ==== ssd_params.svh ====
// Register map, field positions, reset values and divisor codes of the SPI status and data unit.
// Assumes a 32-bit APB slave in which each register takes one aligned word.
`ifndef SSD_PARAMS_SVH
`define SSD_PARAMS_SVH

// Register indices; the byte address is four times the index.
`define SSD_IDX_CTRL       6'h10
`define SSD_IDX_STAT       6'h11
`define SSD_IDX_DATA       6'h12
`define SSD_ADDR_CTRL      ({`SSD_IDX_CTRL, 2'b00})
`define SSD_ADDR_STAT      ({`SSD_IDX_STAT, 2'b00})
`define SSD_ADDR_DATA      ({`SSD_IDX_DATA, 2'b00})

// Control register fields.
`define SSD_CTRL_RXIE      7
`define SSD_CTRL_MSTR      5
`define SSD_CTRL_SPE       1
`define SSD_CTRL_TXIE      0
`define SSD_CTRL_RESET     8'h20

// Status and control register fields.
`define SSD_STAT_RXF       7
`define SSD_STAT_ERROR_IRQ_ENABLE     6
`define SSD_STAT_OVR       5
`define SSD_STAT_MODE_FAULT_FLAG      4
`define SSD_STAT_TXE       3
`define SSD_STAT_MFEN      2
`define SSD_STAT_BDHI      1
`define SSD_STAT_BDLO      0
`define SSD_STAT_WMASK     8'h47

// Baud divisor for each select code.
`define SSD_BD_CODE0       8'h02
`define SSD_BD_CODE1       8'h08
`define SSD_BD_CODE2       8'h20
`define SSD_BD_CODE3       8'h80

// Bits of a transfer and idle pin levels {ss_n, sclk, mosi, miso}.
`define SSD_BITS_LAST      3'h7
`define SSD_PIN_IDLE       4'h8

`endif

// ==== ssd_pkg.sv ====
// Types shared by the SPI status and data unit.
// Assumes ssd_params.svh supplies every numeric constant.
package ssd_pkg;

    typedef logic [7:0] ssd_byte_t;

    typedef enum logic [0:0] {
        SSD_M_IDLE,
        SSD_M_RUN
    } ssd_mstate_t;

endpackage

// ==== ssd_baud_gen.sv ====
// Half-period tick generator for the master serial clock.
// Assumes div is at least two and stays steady while run is high.
`timescale 1ns/100ps
module ssd_baud_gen (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Control
    input  wire logic       run,
    input  wire logic [7:0] div,
    // Tick out, one cycle every div cycles
    output logic            tick
);

    logic [7:0] cnt_reg;

    // Counter restarts whenever the master is idle, so every byte starts with a full half period.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 8'h00;
        end else if (!run || tick) begin
            cnt_reg <= 8'h00;
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end

    assign tick = run && (cnt_reg == div - 8'h01);

endmodule // ssd_baud_gen

// ==== ssd_peer.sv ====
// Peer SPI slave model that faces the block in master use.
// Assumes sclk idles low; data shifts on falling and is caught on rising edges.
`timescale 1ns/100ps
module ssd_peer
    import ssd_pkg::*;
(
    // Link pins
    input  wire logic      sel,
    input  wire logic      sclk,
    input  wire logic      mosi,
    output logic           miso,
    // Byte sent, byte caught and falling edges seen
    input  wire ssd_byte_t tx,
    output ssd_byte_t      rx,
    output logic [3:0]     nbits
);
    ssd_byte_t sh;
    logic      last;

    // A released line shows the inverse of its last bit, so stale data never passes.
    always @(posedge sel) begin
        sh = tx;
        nbits = 4'h0;
    end
    always @(negedge sel) last = sh[7];
    assign miso = sel ? sh[7] : ~last;

    // Catch on the rising edge, shift on the falling edge.
    always @(posedge sclk) if (sel) rx = {rx[6:0], mosi};
    always @(negedge sclk) if (sel) {sh, nbits} = {sh[6:0], 1'h0, nbits + 4'h1};
endmodule // ssd_peer

// ==== ssd_core_bench.sv ====
// Self-checking bench of the SPI status and data unit in master and slave use.
// Assumes the peer model ssd_peer and the constants of ssd_params.svh.
`timescale 1ns/100ps
`include "ssd_params.svh"
module ssd_core_bench;
    import ssd_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_request, err;
    logic        sclk_out, sclk_oe, mosi_out, mosi_oe, miso_out, miso_oe, peer_miso;
    logic        ss_n_in, ss_pin_is_gpio, peer_sel, bsclk, bmosi;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb, nbits;
    ssd_byte_t   peer_tx, peer_rx;
    int          error_cnt, checks, cyc;

    // In slave use the bench drives clock and mosi as the master; miso falls back to the peer.
    ssd_core u_dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
        .irq_request, .sclk_in(sclk_oe ? sclk_out : bsclk), .sclk_out, .sclk_oe,
        .mosi_in(mosi_oe ? mosi_out : bmosi), .mosi_out, .mosi_oe,
        .miso_in(miso_oe ? miso_out : peer_miso), .miso_out, .miso_oe, .ss_n_in, .ss_pin_is_gpio
    );
    ssd_peer u_peer (
        .sel(peer_sel), .sclk(sclk_out), .mosi(mosi_out), .miso(peer_miso), .tx(peer_tx), .rx(peer_rx), .nbits
    );

    // Clock, and a watchdog that cuts a hang short.
    initial begin
        pclk = 1'h0;
        forever #4 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            close_out();
        end
    end

    task automatic close_out();
        if (error_cnt == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One APB transfer; the request stands until pready is seen high at an edge.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'h1, a, {24'h0, d});
    endtask

    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'h0, a, 32'h0);
        chk(nm, e, rd);
    endtask

    // Exchange one byte with the peer and wait past its eighth falling clock edge.
    task automatic xfer(input ssd_byte_t tx, input ssd_byte_t pb);
        int n;
        peer_sel <= 1'h0;
        peer_tx <= pb;
        @(posedge pclk);
        peer_sel <= 1'h1;
        wr(`SSD_ADDR_DATA, tx);
        n = 0;
        while (nbits !== 4'h8 && n < 3000) begin
            @(posedge pclk);
            n++;
        end
        repeat (8) @(posedge pclk);
        chk("peer byte", {24'h0, tx}, {24'h0, peer_rx});
    endtask

    // Measure the serial half period while the byte runs; transmit empty must be back by the first edge.
    task automatic t_baud(input logic [1:0] code, input logic [7:0] bd);
        int n;
        wr(`SSD_ADDR_STAT, {6'h0, code});
        wr(`SSD_ADDR_CTRL, 8'h23);
        chk("master oe", 32'h6, {29'h0, sclk_oe, mosi_oe, miso_oe});
        fork
            xfer({6'h15, code}, 8'h3c);
            begin
                n = 0;
                while (sclk_out !== 1'h1 && n < 400) begin
                    @(posedge pclk);
                    n++;
                end
                chk("irq tx", 32'h1, {31'h0, irq_request});
                n = 0;
                while (sclk_out === 1'h1 && n < 400) begin
                    @(posedge pclk);
                    n++;
                end
                chk("half period", {24'h0, bd}, n);
            end
        join
        wr(`SSD_ADDR_CTRL, 8'ha2);
        chk("irq rx", 32'h1, {31'h0, irq_request});
        apb(1'h0, `SSD_ADDR_DATA, 32'h0);
        if (code != 2'h0) chk("data", 32'h3c, rd);
        @(posedge pclk);
        chk("irq rx clr", 32'h0, {31'h0, irq_request});
    endtask

    // Second byte before the first is read: old byte kept, flag needs status then data read.
    task automatic t_overrun();
        wr(`SSD_ADDR_STAT, 8'h41);
        wr(`SSD_ADDR_CTRL, 8'h22);
        xfer(8'h11, 8'hc3);
        xfer(8'h22, 8'h3c);
        chk("irq err", 32'h1, {31'h0, irq_request});
        wr(`SSD_ADDR_STAT, 8'h01);
        @(posedge pclk);
        chk("irq off", 32'h0, {31'h0, irq_request});
        wr(`SSD_ADDR_STAT, 8'h41);
        rdc("data old", `SSD_ADDR_DATA, 32'hc3);
        rdc("stat ovr kept", `SSD_ADDR_STAT, 32'h69);
        rdc("data again", `SSD_ADDR_DATA, 32'hc3);
        rdc("stat ovr clr", `SSD_ADDR_STAT, 32'h49);
    endtask

    // Select driven low at a master, with the fault enable off and then on.
    task automatic t_fault();
        ss_n_in <= 1'h0;
        repeat (8) @(posedge pclk);
        rdc("stat no fault", `SSD_ADDR_STAT, 32'h49);
        chk("gpio", 32'h1, {31'h0, ss_pin_is_gpio});
        wr(`SSD_ADDR_STAT, 8'h45);
        repeat (8) @(posedge pclk);
        rdc("stat fault", `SSD_ADDR_STAT, 32'h5d);
        chk("gpio mf", 32'h0, {31'h0, ss_pin_is_gpio});
        chk("irq fault", 32'h1, {31'h0, irq_request});
        ss_n_in <= 1'h1;
        wr(`SSD_ADDR_STAT, 8'h41);
        rdc("stat fault kept", `SSD_ADDR_STAT, 32'h59);
        xfer(8'h96, 8'h69);
        rdc("stat fault clr", `SSD_ADDR_STAT, 32'hc9);
        rdc("data", `SSD_ADDR_DATA, 32'h69);
    endtask

    // A slave owns its select pin; its output drives only while selected.
    task automatic t_slave();
        wr(`SSD_ADDR_CTRL, 8'h02);
        chk("gpio slave", 32'h0, {31'h0, ss_pin_is_gpio});
        chk("slave oe", 32'h0, {29'h0, sclk_oe, mosi_oe, miso_oe});
        ss_n_in <= 1'h0;
        repeat (6) @(posedge pclk);
        chk("miso on", 32'h1, {31'h0, miso_oe});
        ss_n_in <= 1'h1;
        repeat (6) @(posedge pclk);
        chk("miso off", 32'h0, {31'h0, miso_oe});
    endtask

    // One slave clock pulse from the bench; each level lasts six cycles so the synchroniser settles.
    task automatic spulse(input logic b, output logic q);
        bmosi <= b;
        repeat (6) @(posedge pclk);
        q = miso_out;
        bsclk <= 1'h1;
        repeat (6) @(posedge pclk);
        bsclk <= 1'h0;
    endtask

    // Slave byte both ways, then select rising mid-byte, then a pulse while deselected.
    task automatic t_sbyte();
        ssd_byte_t sv, got;
        sv = 8'h5a;
        wr(`SSD_ADDR_DATA, 8'ha5);
        ss_n_in <= 1'h0;
        repeat (6) @(posedge pclk);
        for (int i = 7; i >= 0; i--) begin
            spulse(sv[i], got[i]);
        end
        repeat (6) @(posedge pclk);
        chk("slave out", 32'ha5, {24'h0, got});
        rdc("slave stat", `SSD_ADDR_STAT, 32'hc9);
        rdc("slave data", `SSD_ADDR_DATA, 32'h5a);
        wr(`SSD_ADDR_STAT, 8'h45);
        spulse(1'h0, got[0]);
        repeat (6) @(posedge pclk);
        ss_n_in <= 1'h1;
        repeat (6) @(posedge pclk);
        rdc("slave fault", `SSD_ADDR_STAT, 32'h5d);
        spulse(1'h0, got[1]);
        repeat (6) @(posedge pclk);
        chk("slave ignore", 32'h1, {31'h0, miso_out});
    endtask

    // Reset for two cycles, then run the scenarios in turn.
    initial begin
        {presetn, psel, penable, pwrite, peer_sel, paddr, pwdata, bsclk, bmosi} = '0;
        {ss_n_in, pstrb, peer_tx, cyc} = {1'h1, 4'hf, 8'h00, 32'h0};
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        rdc("stat reset", `SSD_ADDR_STAT, 32'h08);
        rdc("ctrl reset", `SSD_ADDR_CTRL, 32'h20);
        chk("irq reset", 32'h0, {31'h0, irq_request});
        rdc("unmapped", 8'h4c, 32'h0);
        chk("pslverr", 32'h1, {31'h0, err});
        t_baud(2'h0, `SSD_BD_CODE0);
        t_baud(2'h1, `SSD_BD_CODE1);
        t_baud(2'h2, `SSD_BD_CODE2);
        t_baud(2'h3, `SSD_BD_CODE3);
        t_overrun();
        t_fault();
        t_slave();
        t_sbyte();
        close_out();
    end
endmodule // ssd_core_bench
